// file: common/cfg_opt_pkg.sv
package cfg_opt_pkg;

    localparam int CFG_W = 14;
    localparam int ADDR_W = 14;
    localparam logic [ADDR_W-1:0] CFG_ADDR = 14'h2007;
    localparam logic [ADDR_W-1:0] TEST_SPACE_LO = 14'h2000;
    localparam logic [ADDR_W-1:0] TEST_SPACE_HI = 14'h3FFF;
    localparam logic [CFG_W-1:0] CFG_ERASED = 14'h3FFF;

    localparam int CP_MSB = 13;
    localparam int CP_LSB = 4;
    localparam int POWERUP_DELAY_ENABLE_N_BIT = 3;
    localparam int WATCHDOG_ENABLE_BIT_BIT = 2;
    localparam int OSC_MSB = 1;
    localparam int OSC_LSB = 0;
    localparam logic [CP_MSB-CP_LSB:0] CP_OFF = 10'h3FF;

    localparam int CLK_KHZ = 40000;
    localparam int POWERUP_DELAY_TIMER_TIME_MS = 72;
    localparam int POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_TIMER_TIME_MS * CLK_KHZ;
    localparam int OST_EDGES = 1024;
    localparam int WDT_TICKS = 256;
    localparam int CNT_W = 22;
    localparam int WDT_W = 16;

    typedef enum logic [1:0] {
        LOW_POWER_CRYSTAL_MODE = 2'h0,
        CRYSTAL_RESONATOR_MODE = 2'h1,
        HIGH_SPEED_CRYSTAL_MODE = 2'h2,
        RESISTOR_CAPACITOR_MODE = 2'h3
    } osc_mode_e;

    typedef enum logic [4:0] {
        ST_LOAD = 5'h01,
        ST_POWERUP_DELAY_TIMER = 5'h02,
        ST_OST = 5'h04,
        ST_RUN = 5'h08,
        ST_SLEEP = 5'h10
    } seq_state_e;

    typedef struct packed {
        logic code_protect;
        logic powerup_delay_timer_en;
        logic wdt_en;
        osc_mode_e osc_mode;
    } cfg_opts_s;

    typedef struct packed {
        logic mode;
        logic we;
        logic re;
        logic [ADDR_W-1:0] addr;
        logic [CFG_W-1:0] wdata;
    } prog_req_s;

endpackage

// file: design/config_word_option_decode.sv
// Contract
// - Programmed bit reads zero, erased reads one.
// - Configuration word lives at address 2007h.
// - Test space reachable only in programming mode; only 2007h is decoded, other test-space addresses read zero and ignore writes.
// - Bits 13:4 zero protect all memory.
// - Bit 3 low enables power-up delay.
// - Bit 2 high enables the watchdog.
// - Bits 1:0 select oscillator mode.
// - Watchdog off only by configuration; own oscillator.
// - Power-up delay 72 ms, power-up only.
// - Start-up timer holds reset until oscillator stable.
// - Crystal modes accept external clock on input.
// - Sleep exits on reset, watchdog, interrupt.
module config_word_option_decode #(
    parameter int POWERUP_DELAY_TIMER_CYCLES = cfg_opt_pkg::POWERUP_DELAY_TIMER_CYCLES,
    parameter int OST_EDGES = cfg_opt_pkg::OST_EDGES,
    parameter int WDT_TICKS = cfg_opt_pkg::WDT_TICKS,
    parameter logic [13:0] CFG_INIT = cfg_opt_pkg::CFG_ERASED
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire cfg_opt_pkg::prog_req_s i_prog,
    input wire logic i_mclr_n,
    input wire logic i_osc_in_pin,
    input wire logic i_wdt_rc_clk,
    input wire logic i_wdt_clear,
    input wire logic i_sleep_req,
    input wire logic i_irq_wake,
    output cfg_opt_pkg::cfg_opts_s o_opts,
    output logic [13:0] o_prog_rdata,
    output logic o_core_reset,
    output logic o_core_run,
    output logic o_sleeping,
    output logic o_osc_amp_en,
    output logic o_wdt_timeout
);
    import cfg_opt_pkg::*;

    typedef struct packed {
        seq_state_e st;
        logic [CFG_W-1:0] nv_word;
        cfg_opts_s opts;
        logic [CNT_W-1:0] cnt;
        logic [WDT_W-1:0] wdt_cnt;
        logic [2:0] osc_sync;
        logic [2:0] rc_sync;
        logic [2:0] mclr_sync;
        logic osc_lvl;
        logic rc_lvl;
        logic mclr_lvl;
        logic wake;
        logic wdt_to;
        logic [CFG_W-1:0] rdata;
    } state_s;

    function automatic cfg_opts_s f_decode(input logic [CFG_W-1:0] w);
        cfg_opts_s o;
        o.code_protect = (w[CP_MSB:CP_LSB] != CP_OFF);
        o.powerup_delay_timer_en = ~w[POWERUP_DELAY_ENABLE_N_BIT];
        o.wdt_en = w[WATCHDOG_ENABLE_BIT_BIT];
        o.osc_mode = osc_mode_e'(w[OSC_MSB:OSC_LSB]);
        return o;
    endfunction

    // A pin level changes only once the second and third stages agree.
    function automatic logic f_settle(input logic [2:0] sync, input logic lvl);
        return (sync[1] == sync[2]) ? sync[2] : lvl;
    endfunction

    localparam state_s RST_STATE = '{
        st: ST_LOAD,
        nv_word: CFG_INIT,
        opts: f_decode(CFG_INIT),
        // The reset pin idles high, so its filter starts there; otherwise a false reset follows release.
        mclr_sync: 3'b111,
        mclr_lvl: 1'b1,
        default: '0
    };

    state_s s_reg;
    state_s s_next;
    logic osc_edge;
    logic rc_tick;
    logic mclr_active;
    logic wdt_hit;
    logic wdt_running;
    logic crystal;
    logic prog_hit;

    always_comb begin
        s_next = s_reg;
        s_next.osc_sync = {s_reg.osc_sync[1:0], i_osc_in_pin};
        s_next.rc_sync = {s_reg.rc_sync[1:0], i_wdt_rc_clk};
        s_next.mclr_sync = {s_reg.mclr_sync[1:0], i_mclr_n};
        s_next.osc_lvl = f_settle(s_reg.osc_sync, s_reg.osc_lvl);
        s_next.rc_lvl = f_settle(s_reg.rc_sync, s_reg.rc_lvl);
        s_next.mclr_lvl = f_settle(s_reg.mclr_sync, s_reg.mclr_lvl);
        // the start-up count runs on input edges, crystal or external clock.
        osc_edge = s_next.osc_lvl & ~s_reg.osc_lvl;
        rc_tick = s_next.rc_lvl & ~s_reg.rc_lvl;
        mclr_active = ~s_reg.mclr_lvl;
        crystal = (s_reg.opts.osc_mode != RESISTOR_CAPACITOR_MODE);

        // the configuration space answers only in programming mode.
        prog_hit = i_prog.mode && (i_prog.addr == CFG_ADDR);
        s_next.rdata = '0;
        if (prog_hit && i_prog.re) begin
            s_next.rdata = s_reg.nv_word;
        end
        if (prog_hit && i_prog.we) begin
            s_next.nv_word = i_prog.wdata;
        end

        // The watchdog has no run-time off switch; it counts only in run and sleep, and there only the sampled option stops it.
        wdt_running = s_reg.opts.wdt_en && (s_reg.st == ST_RUN || s_reg.st == ST_SLEEP);
        wdt_hit = 1'b0;
        s_next.wdt_to = 1'b0;
        if (!wdt_running || i_wdt_clear) begin
            s_next.wdt_cnt = '0;
        end else if (rc_tick) begin
            if (s_reg.wdt_cnt == WDT_W'(WDT_TICKS - 1)) begin
                wdt_hit = 1'b1;
                s_next.wdt_to = 1'b1;
                s_next.wdt_cnt = '0;
            end else begin
                s_next.wdt_cnt = s_reg.wdt_cnt + 1'b1;
            end
        end

        case (s_reg.st)
            ST_LOAD: begin
                // options are latched once here and never again.
                s_next.opts = f_decode(s_reg.nv_word);
                s_next.cnt = '0;
                s_next.st = s_reg.nv_word[POWERUP_DELAY_ENABLE_N_BIT] ? ST_OST : ST_POWERUP_DELAY_TIMER;
            end
            ST_POWERUP_DELAY_TIMER: begin
                if (s_reg.cnt == CNT_W'(POWERUP_DELAY_TIMER_CYCLES - 1)) begin
                    s_next.cnt = '0;
                    s_next.st = ST_OST;
                end else begin
                    s_next.cnt = s_reg.cnt + 1'b1;
                end
            end
            ST_OST: begin
                if (mclr_active) begin
                    s_next.cnt = '0;
                    s_next.wake = 1'b0;
                end else if (!crystal) begin
                    s_next.st = ST_RUN;
                    s_next.wake = 1'b0;
                end else if (osc_edge) begin
                    if (s_reg.cnt == CNT_W'(OST_EDGES - 1)) begin
                        s_next.st = ST_RUN;
                        s_next.wake = 1'b0;
                        s_next.cnt = '0;
                    end else begin
                        s_next.cnt = s_reg.cnt + 1'b1;
                    end
                end
            end
            ST_RUN: begin
                // Later resets skip the power-up delay and only restart the oscillator wait.
                if (mclr_active || wdt_hit) begin
                    s_next.st = ST_OST;
                    s_next.cnt = '0;
                    s_next.wake = 1'b0;
                end else if (i_sleep_req) begin
                    s_next.st = ST_SLEEP;
                    s_next.wdt_cnt = '0;
                end
            end
            ST_SLEEP: begin
                if (mclr_active) begin
                    s_next.st = ST_OST;
                    s_next.cnt = '0;
                    s_next.wake = 1'b0;
                end else if (wdt_hit || i_irq_wake) begin
                    s_next.st = ST_OST;
                    s_next.cnt = '0;
                    s_next.wake = 1'b1;
                end
            end
            default: begin
                s_next = RST_STATE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_reg <= RST_STATE;
        end else begin
            s_reg <= s_next;
        end
    end

    // A wake from sleep waits for the oscillator but keeps the core out of reset.
    assign o_core_reset = (s_reg.st == ST_LOAD) || (s_reg.st == ST_POWERUP_DELAY_TIMER) ||
        ((s_reg.st == ST_OST) && !s_reg.wake);
    assign o_core_run = (s_reg.st == ST_RUN);
    assign o_sleeping = (s_reg.st == ST_SLEEP);
    assign o_osc_amp_en = crystal && (s_reg.st != ST_SLEEP);
    assign o_opts = s_reg.opts;
    assign o_prog_rdata = s_reg.rdata;
    assign o_wdt_timeout = s_reg.wdt_to;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence seq_enter_powerup_delay_timer;
        (s_reg.st == ST_LOAD) && !s_reg.nv_word[POWERUP_DELAY_ENABLE_N_BIT] ##1 (s_reg.st == ST_POWERUP_DELAY_TIMER);
    endsequence

    sequence seq_wake_irq;
        (s_reg.st == ST_SLEEP) && i_irq_wake && !mclr_active;
    endsequence

    AST_CFG_READ: assert property (
        i_prog.mode && i_prog.re && (i_prog.addr == CFG_ADDR)
        |=> o_prog_rdata == $past(s_reg.nv_word))
        else $error("Configuration word read returned wrong data.");

    AST_NO_RUN_ACCESS: assert property (
        !i_prog.mode |=> (o_prog_rdata == '0) && $stable(s_reg.nv_word))
        else $error("Configuration space touched outside programming mode.");

    AST_CP_DECODE: assert property (
        (s_reg.st == ST_LOAD)
        |=> o_opts.code_protect == ($past(s_reg.nv_word[CP_MSB:CP_LSB]) != CP_OFF))
        else $error("Code protect decode wrong.");

    AST_POWERUP_DELAY_TIMER_SKIP: assert property (
        !i_rst && (s_reg.st == ST_LOAD) && s_reg.nv_word[POWERUP_DELAY_ENABLE_N_BIT] |=> (s_reg.st == ST_OST))
        else $error("Power-up delay ran while disabled.");

    AST_WDT_OFF: assert property (
        !o_opts.wdt_en |-> (s_reg.wdt_cnt == '0) && !o_wdt_timeout)
        else $error("Watchdog active while disabled.");

    AST_OSC_MODE: assert property (
        (s_reg.st == ST_LOAD) |=> o_opts.osc_mode == $past(s_reg.nv_word[OSC_MSB:OSC_LSB]))
        else $error("Oscillator mode decode wrong.");

    AST_POWERUP_DELAY_TIMER_HOLD: assert property (
        seq_enter_powerup_delay_timer |-> o_core_reset [*8])
        else $error("Core left reset during power-up delay.");

    AST_RC_NO_OST: assert property (
        (s_reg.st == ST_OST) && !crystal && !mclr_active |=> (s_reg.st == ST_RUN))
        else $error("Start-up wait applied in resistor-capacitor mode.");

    AST_IRQ_WAKE: assert property (
        seq_wake_irq |=> (s_reg.st == ST_OST) && !o_core_reset)
        else $error("Interrupt did not wake from sleep cleanly.");

    AST_OPTS_STABLE: assert property (
        (s_reg.st != ST_LOAD) |=> $stable(o_opts))
        else $error("Options changed after power-on load.");

endmodule

// file: dv/osc_partner.sv
module osc_partner (
    input wire logic i_run,
    output logic o_osc_in_pin,
    output logic o_wdt_rc_clk
);
    timeunit 1ns;
    timeprecision 100ps;
    // Periods are whole multiples of the core clock, and pin edges land on its falling edges, away from the sampling edge.
    initial begin
        o_osc_in_pin = 1'b0;
        forever #100 o_osc_in_pin = ~o_osc_in_pin;
    end
    // The watchdog source is separate and only ticks while the bench asks for it.
    initial begin
        o_wdt_rc_clk = 1'b0;
        forever #150 o_wdt_rc_clk = i_run & ~o_wdt_rc_clk;
    end
endmodule

// file: dv/config_word_option_decode_test.sv
module config_word_option_decode_test;
    timeunit 1ns;
    timeprecision 100ps;
    import cfg_opt_pkg::*;
    `define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
    logic clk = 1'b0, rst = 1'b1, mclr_n = 1'b1, wdt_run = 1'b0;
    logic wdt_clr = 1'b0, sleep = 1'b0, irq = 1'b0;
    prog_req_s prog = '0;
    logic osc, wdt_clk, core_reset, core_run, sleeping, amp, wdt_to, core_reset_b, amp_b;
    cfg_opts_s opts, opts_b;
    logic [13:0] rdata;
    logic core_run_b, sleeping_b, wdt_to_b;
    logic [13:0] rdata_b;
    int err_count = 0;
    int checks = 0;

    initial forever #12.5 clk = ~clk;

    osc_partner partner (.i_run(wdt_run), .o_osc_in_pin(osc), .o_wdt_rc_clk(wdt_clk));

    config_word_option_decode #(.POWERUP_DELAY_TIMER_CYCLES(20), .OST_EDGES(4), .WDT_TICKS(4)) DUT (
        .i_clk(clk), .i_rst(rst), .i_prog(prog), .i_mclr_n(mclr_n), .i_osc_in_pin(osc),
        .i_wdt_rc_clk(wdt_clk), .i_wdt_clear(wdt_clr), .i_sleep_req(sleep), .i_irq_wake(irq),
        .o_opts(opts), .o_prog_rdata(rdata), .o_core_reset(core_reset), .o_core_run(core_run),
        .o_sleeping(sleeping), .o_osc_amp_en(amp), .o_wdt_timeout(wdt_to));

    // A second part with every bit programmed, since the stored word reloads on reset.
    config_word_option_decode #(.POWERUP_DELAY_TIMER_CYCLES(20), .OST_EDGES(4), .WDT_TICKS(4),
        .CFG_INIT(14'h0000)) DUT_B (
        .i_clk(clk), .i_rst(rst), .i_prog(prog), .i_mclr_n(mclr_n), .i_osc_in_pin(osc),
        .i_wdt_rc_clk(wdt_clk), .i_wdt_clear(wdt_clr), .i_sleep_req(sleep), .i_irq_wake(irq),
        .o_opts(opts_b), .o_prog_rdata(rdata_b), .o_core_reset(core_reset_b), .o_core_run(core_run_b),
        .o_sleeping(sleeping_b), .o_osc_amp_en(amp_b), .o_wdt_timeout(wdt_to_b));

    task end_of_test;
        $display("errors=%0d checks=%0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    function automatic logic watch(int s);
        case (s)
            0: return core_run;
            1: return wdt_to;
            2: return ~core_reset_b;
            3: return core_reset;
            default: return sleeping;
        endcase
    endfunction

    task automatic wait_for(input int s, input int n);
        int i;
        #1;
        for (i = 0; i < n && watch(s) !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        `CHK(watch(s), 1'b1)
        if (watch(s) !== 1'b1) end_of_test;
    endtask

    task automatic access(input logic m, w, r, input logic [13:0] a, d);
        @(posedge clk) prog <= '{m, w, r, a, d};
        @(posedge clk) prog <= '0;
        #1;
    endtask

    task t_reset;
        #1;
        `CHK(opts.code_protect, 1'b0)
        `CHK(opts.powerup_delay_timer_en, 1'b0)
        `CHK(opts.wdt_en, 1'b1)
        `CHK(opts.osc_mode, RESISTOR_CAPACITOR_MODE)
        `CHK(opts_b, {1'b1, 1'b1, 1'b0, LOW_POWER_CRYSTAL_MODE})
        `CHK(core_reset, 1'b1)
        @(posedge clk) rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(core_run, 1'b1)
        `CHK(amp, 1'b0)
        repeat (16) @(posedge clk);
        #1;
        `CHK(core_reset_b, 1'b1)
        wait_for(2, 200);
        `CHK(core_run_b, 1'b1)
        `CHK(amp_b, 1'b1)
    endtask

    task t_prog;
        access(1'b1, 1'b0, 1'b1, CFG_ADDR, 14'h0000);
        `CHK(rdata, CFG_ERASED)
        `CHK(rdata_b, 14'h0000)
        access(1'b1, 1'b1, 1'b0, CFG_ADDR, 14'h1234);
        access(1'b1, 1'b0, 1'b1, CFG_ADDR, 14'h0000);
        `CHK(rdata, 14'h1234)
        `CHK(rdata_b, 14'h1234)
        access(1'b0, 1'b1, 1'b0, CFG_ADDR, 14'h0000);
        access(1'b1, 1'b0, 1'b1, CFG_ADDR, 14'h0000);
        `CHK(rdata, 14'h1234)
        access(1'b0, 1'b0, 1'b1, CFG_ADDR, 14'h0000);
        `CHK(rdata, 14'h0000)
        access(1'b1, 1'b0, 1'b1, TEST_SPACE_LO, 14'h0000);
        `CHK(rdata, 14'h0000)
        `CHK(opts.osc_mode, RESISTOR_CAPACITOR_MODE)
    endtask

    task t_wdt;
        int n;
        n = 0;
        @(posedge clk) wdt_clr <= 1'b1;
        wdt_run <= 1'b1;
        repeat (100) begin
            @(posedge clk);
            #1;
            if (wdt_to !== 1'b0) n++;
        end
        `CHK(n, 0)
        @(posedge clk) wdt_clr <= 1'b0;
        wait_for(1, 200);
        `CHK(wdt_to_b, 1'b0)
        @(posedge clk) wdt_run <= 1'b0;
        wait_for(0, 20);
        `CHK(core_reset_b, 1'b0)
    endtask

    // An external reset in run skips the power-up delay, so the second part only redoes the oscillator wait and is back within the 40-cycle limit.
    task t_mclr;
        @(posedge clk) mclr_n <= 1'b0;
        repeat (10) @(posedge clk);
        #1;
        `CHK(core_reset, 1'b1)
        `CHK(core_reset_b, 1'b1)
        `CHK(opts.osc_mode, RESISTOR_CAPACITOR_MODE)
        @(posedge clk) mclr_n <= 1'b1;
        wait_for(0, 10);
        wait_for(2, 40);
    endtask

    task t_sleep;
        @(posedge clk) sleep <= 1'b1;
        @(posedge clk) sleep <= 1'b0;
        wait_for(4, 5);
        `CHK(core_run, 1'b0)
        `CHK(sleeping_b, 1'b1)
        `CHK(amp_b, 1'b0)
        @(posedge clk) irq <= 1'b1;
        wait_for(0, 10);
        `CHK(core_reset, 1'b0)
        @(posedge clk) irq <= 1'b0;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        t_reset;
        t_prog;
        t_wdt;
        t_mclr;
        t_sleep;
        end_of_test;
    end
endmodule
